// ---- core/dfu_cmd_map.vh ----
// constants for the firmware-upgrade command interpreter
`ifndef DFU_CMD_MAP_VH
`define DFU_CMD_MAP_VH
// command identifiers
`define ID_ERASE_START 8'h04
`define ID_READ 8'h05
// selector groups
`define GRP_BOOT 8'h00
`define GRP_CFG 8'h01
`define GRP_HW 8'h02
`define GRP_START 8'h03
`define GRP_ERASE 8'h00
// read selectors in the config group; SEL_VER, SEL_ID1 and SEL_ID2 belong to the boot group
`define SEL_BOOT_STATUS 8'h00
`define SEL_BOOT_VECTOR 8'h01
`define SEL_P1 8'h02
`define SEL_P3 8'h03
`define SEL_P4 8'h04
`define SEL_SECURITY 8'h05
`define SEL_EXTRA 8'h06
`define SEL_MAN 8'h30
`define SEL_FAM 8'h31
`define SEL_PROD 8'h60
`define SEL_REV 8'h61
`define SEL_VER 8'h00
`define SEL_ID1 8'h01
`define SEL_ID2 8'h02
// only selector of the hardware group
`define SEL_HW 8'h00
// erase selectors (high address byte of block base)
`define ERASE_BLK0 8'h00
`define ERASE_BLK1 8'h20
`define ERASE_BLK2 8'h40
`define ERASE_FULL 8'hff
// start selectors
`define START_WDT 8'h00
`define START_JUMP 8'h01
// flash address ranges
`define BLK0_LO 15'h0000
`define BLK0_HI 15'h1fff
`define BLK1_LO 15'h2000
`define BLK1_HI 15'h3fff
`define BLK2_LO 15'h4000
`define BLK2_HI 15'h7fff
`define ERASED_BYTE 8'hff
`define APP_ENTRY 16'h0000
// status codes returned to status requests
`define ST_OK 4'h0
`define ST_ERR_WRITE 4'h3
`define ST_ERR_VENDOR 4'hb
`define ST_ERR_UNKNOWN 4'he
// command lengths
`define LEN_EMPTY 3'd0
`define LEN_RW 3'd2
`define LEN_START_S 3'd3
`define LEN_START_L 3'd5
`endif

// ---- core/flash_eraser.v ----
// walks an address range issuing one erase strobe per byte
`timescale 1ns/10ps
module flash_eraser (
  input wire clk, // system clock
  input wire rst_n, // synchronised reset, active low
  input wire start, // one-cycle start pulse
  input wire [14:0] lo_addr, // first address
  input wire [14:0] hi_addr, // last address
  output reg busy_ff, // range walk in progress
  output reg we_ff, // erase strobe
  output reg [14:0] addr_ff // address being erased
);
  reg [14:0] end_ff;
  // step through the range, one address per clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      we_ff <= 1'b0;
      addr_ff <= 15'h0000;
      end_ff <= 15'h0000;
    end else if (start && !busy_ff) begin
      busy_ff <= 1'b1;
      we_ff <= 1'b1;
      addr_ff <= lo_addr;
      end_ff <= hi_addr;
    end else if (busy_ff) begin
      if (addr_ff == end_ff) begin
        busy_ff <= 1'b0;
        we_ff <= 1'b0;
      end else begin
        addr_ff <= addr_ff + 15'h0001;
      end
    end
  end
endmodule // flash_eraser

// ---- core/dfu_cmd_handler.v ----
// firmware-upgrade read, erase and application-start command interpreter
// Notes on behaviour
// - group 00h boot info, 01h config/id bytes, 02h hardware byte.
// - read status is vendor error when protected, OK otherwise.
// - after OK, upload returns exactly one byte of the selected field.
// - block erase clears only its own address range.
// - full erase clears 32K and sets boot status, vector, security to FFh.
// - erase status is write error when protected; full erase always runs.
// - selector 03h/00h enables watchdog and idles until reset pulse.
// - selector 03h/01h jumps to given address without reset, default 0000h.
// - no response is sent after the watchdog start; after a jump start, status and upload requests are still answered.
`timescale 1ns/10ps
`include "dfu_cmd_map.vh"
module dfu_cmd_handler (
  input wire clk, // 100 MHz system clock
  input wire resetn, // asynchronous reset, active low
  input wire cmd_valid, // one-cycle pulse: download data stage complete
  input wire [2:0] cmd_len, // bytes in download data stage
  input wire [7:0] cmd_b0, // command identifier
  input wire [7:0] cmd_b1, // data[0]
  input wire [7:0] cmd_b2, // data[1]
  input wire [7:0] cmd_b3, // data[2]
  input wire [7:0] cmd_b4, // data[3]
  input wire status_req, // one-cycle pulse: status request
  input wire clr_status, // one-cycle pulse: clear-status request
  input wire upload_req, // one-cycle pulse: upload request
  input wire prog_protected, // part protected against program access
  input wire [7:0] boot_status_byte, // current boot status byte
  input wire [7:0] software_boot_vector, // current software boot vector
  input wire [7:0] cfg_p1, // port1_config_byte
  input wire [7:0] cfg_p3, // port3_config_byte
  input wire [7:0] cfg_p4, // port4_config_byte
  input wire [7:0] software_security_byte, // current software security byte
  input wire [7:0] extra_config_byte, // extra configuration byte
  input wire [7:0] hardware_config_byte, // hardware configuration byte
  input wire [7:0] id_ver, // bootloader version
  input wire [7:0] id_boot1, // boot id1
  input wire [7:0] id_boot2, // boot id2
  input wire [7:0] id_man, // manufacturer code
  input wire [7:0] id_fam, // family code
  input wire [7:0] id_prod, // product name
  input wire [7:0] id_rev, // product revision
  output reg status_valid_ff, // pulse: status answer valid
  output reg [3:0] status_ff, // status code
  output reg status_busy_ff, // erase still running
  output reg up_valid_ff, // pulse: one upload byte valid
  output reg [7:0] up_data_ff, // upload byte
  output reg up_empty_ff, // pulse: upload has no data
  output reg flash_we_ff, // flash byte erase strobe
  output reg [14:0] flash_addr_ff, // flash byte address
  output reg cfg_default_ff, // pulse: boot status, vector and security bytes to ffh
  output reg wdt_enable_ff, // watchdog enable, held until reset
  output reg jump_ff, // pulse: jump to application
  output reg [15:0] jump_addr_ff // jump target
);
  reg rst_meta_ff, rstn_sync_ff;
  reg prot_meta_ff, prot_ff;
  reg [3:0] st_ff;
  reg [7:0] sel_data_ff;
  reg sel_ok_ff;
  reg start_pend_ff, start_mode_ff;
  reg [15:0] start_addr_ff;
  reg erase_go_ff, idle_loop_ff;
  reg [14:0] er_lo_ff, er_hi_ff;
  wire er_busy, er_we;
  wire [14:0] er_addr;

  // reset release through two flip-flops
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rstn_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rstn_sync_ff <= rst_meta_ff;
    end
  end

  // protection pin synchroniser
  always @(posedge clk or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      prot_meta_ff <= 1'b0;
      prot_ff <= 1'b0;
    end else begin
      prot_meta_ff <= prog_protected;
      prot_ff <= prot_meta_ff;
    end
  end

  // read selector decode; returns {valid, byte}
  function [8:0] read_sel;
    input [7:0] grp;
    input [7:0] sel;
    begin
      read_sel = 9'h000;
      case (grp)
        `GRP_BOOT: begin
          case (sel)
            `SEL_VER: read_sel = {1'b1, id_ver};
            `SEL_ID1: read_sel = {1'b1, id_boot1};
            `SEL_ID2: read_sel = {1'b1, id_boot2};
            default: read_sel = 9'h000;
          endcase
        end
        `GRP_CFG: begin
          case (sel)
            `SEL_BOOT_STATUS: read_sel = {1'b1, boot_status_byte};
            `SEL_BOOT_VECTOR: read_sel = {1'b1, software_boot_vector};
            `SEL_P1: read_sel = {1'b1, cfg_p1};
            `SEL_P3: read_sel = {1'b1, cfg_p3};
            `SEL_P4: read_sel = {1'b1, cfg_p4};
            `SEL_SECURITY: read_sel = {1'b1, software_security_byte};
            `SEL_EXTRA: read_sel = {1'b1, extra_config_byte};
            `SEL_MAN: read_sel = {1'b1, id_man};
            `SEL_FAM: read_sel = {1'b1, id_fam};
            `SEL_PROD: read_sel = {1'b1, id_prod};
            `SEL_REV: read_sel = {1'b1, id_rev};
            default: read_sel = 9'h000;
          endcase
        end
        `GRP_HW: read_sel = (sel == `SEL_HW) ? {1'b1, hardware_config_byte} : 9'h000;
        default: read_sel = 9'h000;
      endcase
    end
  endfunction

  wire [8:0] rd = read_sel(cmd_b1, cmd_b2);

  // command decode, status and upload answers
  always @(posedge clk or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      st_ff <= `ST_OK;
      sel_data_ff <= 8'h00;
      sel_ok_ff <= 1'b0;
      start_pend_ff <= 1'b0;
      start_mode_ff <= 1'b0;
      start_addr_ff <= `APP_ENTRY;
      erase_go_ff <= 1'b0;
      er_lo_ff <= `BLK0_LO;
      er_hi_ff <= `BLK0_HI;
      cfg_default_ff <= 1'b0;
      wdt_enable_ff <= 1'b0;
      idle_loop_ff <= 1'b0;
      jump_ff <= 1'b0;
      jump_addr_ff <= `APP_ENTRY;
      status_valid_ff <= 1'b0;
      status_ff <= `ST_OK;
      status_busy_ff <= 1'b0;
      up_valid_ff <= 1'b0;
      up_data_ff <= 8'h00;
      up_empty_ff <= 1'b0;
    end else begin
      erase_go_ff <= 1'b0;
      cfg_default_ff <= 1'b0;
      jump_ff <= 1'b0;
      status_valid_ff <= 1'b0;
      up_valid_ff <= 1'b0;
      up_empty_ff <= 1'b0;
      status_busy_ff <= er_busy | erase_go_ff;
      if (clr_status)
        st_ff <= `ST_OK;
      if (idle_loop_ff) begin
        // watchdog enabled: idle, ignore commands, status and upload requests until reset; clear-status still resets st_ff
      end else if (cmd_valid && start_pend_ff && cmd_len == `LEN_EMPTY) begin
        // an empty download right after the start command launches the application silently
        start_pend_ff <= 1'b0;
        if (start_mode_ff) begin
          jump_ff <= 1'b1;
          jump_addr_ff <= start_addr_ff;
        end else begin
          wdt_enable_ff <= 1'b1;
          idle_loop_ff <= 1'b1;
        end
      end else if (cmd_valid) begin
        start_pend_ff <= 1'b0;
        sel_ok_ff <= 1'b0;
        if (cmd_b0 == `ID_READ && cmd_len == `LEN_RW && rd[8]) begin
          sel_data_ff <= rd[7:0];
          sel_ok_ff <= !prot_ff;
          st_ff <= prot_ff ? `ST_ERR_VENDOR : `ST_OK;
        end else if (cmd_b0 == `ID_ERASE_START && cmd_b1 == `GRP_ERASE && cmd_len == `LEN_RW) begin
          case (cmd_b2)
            `ERASE_BLK0: begin
              er_lo_ff <= `BLK0_LO;
              er_hi_ff <= `BLK0_HI;
              erase_go_ff <= !prot_ff;
              st_ff <= prot_ff ? `ST_ERR_WRITE : `ST_OK;
            end
            `ERASE_BLK1: begin
              er_lo_ff <= `BLK1_LO;
              er_hi_ff <= `BLK1_HI;
              erase_go_ff <= !prot_ff;
              st_ff <= prot_ff ? `ST_ERR_WRITE : `ST_OK;
            end
            `ERASE_BLK2: begin
              er_lo_ff <= `BLK2_LO;
              er_hi_ff <= `BLK2_HI;
              erase_go_ff <= !prot_ff;
              st_ff <= prot_ff ? `ST_ERR_WRITE : `ST_OK;
            end
            `ERASE_FULL: begin
              er_lo_ff <= `BLK0_LO;
              er_hi_ff <= `BLK2_HI;
              erase_go_ff <= 1'b1;
              cfg_default_ff <= 1'b1;
              st_ff <= prot_ff ? `ST_ERR_WRITE : `ST_OK;
            end
            default: st_ff <= `ST_ERR_UNKNOWN;
          endcase
        end else if (cmd_b0 == `ID_ERASE_START && cmd_b1 == `GRP_START && cmd_b2 == `START_WDT
                     && (cmd_len == `LEN_START_S || cmd_len == `LEN_START_L)) begin
          start_pend_ff <= 1'b1;
          start_mode_ff <= 1'b0;
        end else if (cmd_b0 == `ID_ERASE_START && cmd_b1 == `GRP_START && cmd_b2 == `START_JUMP
                     && (cmd_len == `LEN_START_S || cmd_len == `LEN_START_L)) begin
          start_pend_ff <= 1'b1;
          start_mode_ff <= 1'b1;
          start_addr_ff <= (cmd_len == `LEN_START_L) ? {cmd_b3, cmd_b4} : `APP_ENTRY;
        end else begin
          st_ff <= `ST_ERR_UNKNOWN;
        end
      end
      // status answer, one cycle after the request
      if (status_req && !idle_loop_ff) begin
        status_valid_ff <= 1'b1;
        status_ff <= st_ff;
      end
      // upload: one byte of the selected field, else empty
      if (upload_req && !idle_loop_ff) begin
        if (sel_ok_ff && st_ff == `ST_OK) begin
          up_valid_ff <= 1'b1;
          up_data_ff <= sel_data_ff;
        end else begin
          up_empty_ff <= 1'b1;
        end
      end
    end
  end

  flash_eraser u_eraser (
    .clk(clk),
    .rst_n(rstn_sync_ff),
    .start(erase_go_ff),
    .lo_addr(er_lo_ff),
    .hi_addr(er_hi_ff),
    .busy_ff(er_busy),
    .we_ff(er_we),
    .addr_ff(er_addr)
  );

  // register the flash strobe and address onto the outputs
  always @(posedge clk or negedge rstn_sync_ff) begin
    if (!rstn_sync_ff) begin
      flash_we_ff <= 1'b0;
      flash_addr_ff <= `BLK0_LO;
    end else begin
      flash_we_ff <= er_we;
      flash_addr_ff <= er_addr;
    end
  end
endmodule // dfu_cmd_handler

// ---- bench/dfu_cmd_handler_assertions.sv ----
// port checker for the command interpreter
`timescale 1ns/10ps
module dfu_cmd_chk (
  input wire clk, // clock
  input wire resetn, // reset
  input wire cmd_valid, // command
  input wire [2:0] cmd_len, // length
  input wire [7:0] cmd_b0, // id
  input wire [7:0] cmd_b1, // group
  input wire [7:0] cmd_b2, // selector
  input wire status_req, // status ask
  input wire upload_req, // upload ask
  input wire prog_protected, // protection pin
  input wire status_valid_ff, // status out
  input wire status_busy_ff, // busy
  input wire up_valid_ff, // upload byte
  input wire up_empty_ff, // empty upload
  input wire flash_we_ff, // strobe
  input wire [14:0] flash_addr_ff, // address
  input wire cfg_default_ff, // defaults
  input wire wdt_enable_ff, // watchdog
  input wire jump_ff // jump
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // an idle two-byte erase command
  wire erase_go = cmd_valid && cmd_len == 3'd2 && cmd_b0 == 8'h04 && cmd_b1 == 8'h00 && !status_busy_ff;
  status_ans_a: assert property (status_req && !wdt_enable_ff |=> status_valid_ff)
    else $error("status answer missing");
  upload_one_a: assert property (upload_req && !wdt_enable_ff |=> up_valid_ff != up_empty_ff)
    else $error("upload answer wrong");
  full_dflt_a: assert property (erase_go && cmd_b2 == 8'hff |=> cfg_default_ff)
    else $error("defaults not set");
  blk_first_a: assert property (erase_go && !prog_protected && cmd_b2 == 8'h20 |-> ##3 flash_we_ff
    && flash_addr_ff == 15'h2000)
    else $error("block erase start wrong");
  busy_rise_a: assert property (erase_go && !prog_protected && cmd_b2 == 8'h40 |-> ##2 status_busy_ff [*2])
    else $error("busy not raised");
  prot_skip_a: assert property (erase_go && prog_protected && cmd_b2 != 8'hff |-> ##3 !flash_we_ff)
    else $error("protected block erased");
  addr_step_a: assert property (flash_we_ff && $past(flash_we_ff) |-> flash_addr_ff == $past(flash_addr_ff) + 15'h1)
    else $error("erase address skipped");
  we_busy_a: assert property (flash_we_ff |-> status_busy_ff)
    else $error("strobe while idle");
  wdt_hold_a: assert property ($rose(wdt_enable_ff) |=> wdt_enable_ff [*8])
    else $error("watchdog dropped");
  quiet_wdt_a: assert property ($past(wdt_enable_ff) |-> !status_valid_ff && !up_valid_ff && !up_empty_ff)
    else $error("answer after start");
  cover property (cfg_default_ff);
  cover property (jump_ff);
  cover property (up_valid_ff);
endmodule // dfu_cmd_chk
bind dfu_cmd_handler dfu_cmd_chk u_chk (.clk, .resetn, .cmd_valid, .cmd_len, .cmd_b0, .cmd_b1, .cmd_b2, .status_req,
  .upload_req, .prog_protected, .status_valid_ff, .status_busy_ff, .up_valid_ff, .up_empty_ff, .flash_we_ff,
  .flash_addr_ff,
  .cfg_default_ff, .wdt_enable_ff, .jump_ff);

// ---- bench/dfu_host_model.sv ----
// host model issuing download, status, clear and upload requests
`timescale 1ns/10ps
module dfu_host_model (
  input wire clk, // clock
  output logic cmd_valid = 1'b0, // data stage done
  output logic [2:0] cmd_len = 3'd0, // byte count
  output logic [7:0] cmd_b0 = 8'h00, // id
  output logic [7:0] cmd_b1 = 8'h00, // data 0
  output logic [7:0] cmd_b2 = 8'h00, // data 1
  output logic [7:0] cmd_b3 = 8'h00, // data 2
  output logic [7:0] cmd_b4 = 8'h00, // data 3
  output logic status_req = 1'b0, // status ask
  output logic clr_status = 1'b0, // clear ask
  output logic upload_req = 1'b0 // upload ask
);
  // one download of n bytes; bytes flip once released
  task automatic send(input [2:0] n, input [7:0] a, b, c, d, e);
    @(negedge clk);
    {cmd_len, cmd_b0, cmd_b1, cmd_b2, cmd_b3, cmd_b4} = {n, a, b, c, d, e};
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    {cmd_b0, cmd_b1, cmd_b2, cmd_b3, cmd_b4} = ~{a, b, c, d, e};
  endtask
  // one-cycle request: 0 status, 1 clear, 2 upload
  task automatic pulse(input int k);
    @(negedge clk);
    {upload_req, clr_status, status_req} = 3'b001 << k;
    @(negedge clk);
    {upload_req, clr_status, status_req} = 3'b000;
  endtask
endmodule // dfu_host_model

// ---- bench/dfu_read_erase_start_handler_tb.sv ----
// self-checking bench for the command interpreter
`timescale 1ns/10ps
`include "dfu_cmd_map.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; $display("Error %s exp %h seen %h", n, e, s); end end
module dfu_read_erase_start_handler_tb;
  logic clk = 1'b0, resetn = 1'b0, prog_protected = 1'b0, seen_dflt, run;
  logic [15:0] rnd = 16'd20914, n;
  logic [14:0] first, last;
  logic [7:0] v [0:14], s;
  int checks = 0, err_total = 0, t;
  wire cmd_valid, status_req, clr_status, upload_req;
  wire [2:0] cmd_len;
  wire [7:0] cmd_b0, cmd_b1, cmd_b2, cmd_b3, cmd_b4;
  wire status_valid_ff, status_busy_ff, up_valid_ff, up_empty_ff, flash_we_ff, cfg_default_ff, wdt_enable_ff, jump_ff;
  wire [3:0] status_ff;
  wire [7:0] up_data_ff;
  wire [14:0] flash_addr_ff;
  wire [15:0] jump_addr_ff;
  // group and selector of each entry of v
  localparam logic [15:0] sel_tab [0:14] = '{16'h0100, 16'h0101, 16'h0102, 16'h0103, 16'h0104, 16'h0105, 16'h0106,
    16'h0200, 16'h0000, 16'h0001, 16'h0002, 16'h0130, 16'h0131, 16'h0160, 16'h0161};
  dfu_host_model host (.clk, .cmd_valid, .cmd_len, .cmd_b0, .cmd_b1, .cmd_b2, .cmd_b3, .cmd_b4, .status_req,
    .clr_status, .upload_req);
  dfu_cmd_handler DUT (.clk, .resetn, .cmd_valid, .cmd_len, .cmd_b0, .cmd_b1, .cmd_b2, .cmd_b3, .cmd_b4, .status_req,
    .clr_status, .upload_req, .prog_protected, .boot_status_byte(v[0]), .software_boot_vector(v[1]),
    .cfg_p1(v[2]), .cfg_p3(v[3]), .cfg_p4(v[4]), .software_security_byte(v[5]), .extra_config_byte(v[6]),
    .hardware_config_byte(v[7]), .id_ver(v[8]), .id_boot1(v[9]), .id_boot2(v[10]),
    .id_man(v[11]), .id_fam(v[12]), .id_prod(v[13]), .id_rev(v[14]), .status_valid_ff, .status_ff, .status_busy_ff,
    .up_valid_ff, .up_data_ff, .up_empty_ff, .flash_we_ff, .flash_addr_ff, .cfg_default_ff, .wdt_enable_ff, .jump_ff,
    .jump_addr_ff);
  // 100 MHz clock
  initial forever #5 clk = ~clk;
  // random source and expected erase extents
  function automatic [15:0] nxt_rand(input [15:0] r);
    nxt_rand = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
  endfunction
  function automatic [15:0] exp_cnt(input [7:0] e);
    exp_cnt = (e == 8'hff) ? 16'h8000 : (e == 8'h40) ? 16'h4000 : 16'h2000;
  endfunction
  function automatic [14:0] exp_lo(input [7:0] e);
    exp_lo = (e == 8'hff) ? 15'h0000 : {e[6:0], 8'h00};
  endfunction
  // status request and its one answer
  task automatic stat(input [3:0] e);
    host.pulse(0);
    `CHK("status_valid", 1'b1, status_valid_ff)
    `CHK("status", e, status_ff)
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial begin
    for (int j = 0; j < 15; j++) v[j] = 8'h00;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    repeat (5) @(negedge clk);
    for (int i = 0; i < 15; i++) begin
      for (int j = 0; j < 15; j++) begin
        rnd = nxt_rand(rnd);
        v[j] = rnd[7:0];
      end
      prog_protected = rnd[9];
      repeat (3) @(negedge clk);
      host.send(3'd2, `ID_READ, sel_tab[i][15:8], sel_tab[i][7:0], rnd[15:8], rnd[7:0]);
      stat(prog_protected ? `ST_ERR_VENDOR : `ST_OK);
      host.pulse(2);
      `CHK("up_valid", !prog_protected, up_valid_ff)
      if (prog_protected) `CHK("up_empty", 1'b1, up_empty_ff)
      else `CHK("up_data", v[i], up_data_ff)
    end
    prog_protected = 1'b0;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 2; k++) begin
      host.send(3'd2, k ? `ID_READ : 8'h07, 8'h01, 8'h07, 8'h00, 8'h00);
      stat(`ST_ERR_UNKNOWN);
      host.pulse(1);
      stat(`ST_OK);
    end
    for (int k = 0; k < 4; k++) begin
      s = (k == 3) ? `ERASE_FULL : {1'b0, k[1:0], 5'h00};
      prog_protected = k[0];
      // a protected part only runs the full erase
      run = !prog_protected || s == `ERASE_FULL;
      first = 15'h5555;
      last = 15'h5555;
      repeat (3) @(negedge clk);
      host.send(3'd2, `ID_ERASE_START, `GRP_ERASE, s, rnd[7:0], rnd[15:8]);
      n = 16'h0000;
      seen_dflt = cfg_default_ff;
      for (t = 0; t < 40000 && (t < 4 || status_busy_ff); t++) begin
        @(negedge clk);
        if (flash_we_ff) begin
          if (n == 16'h0000) first = flash_addr_ff;
          last = flash_addr_ff;
          n++;
        end
        seen_dflt |= cfg_default_ff;
      end
      if (t == 40000) begin
        err_total++;
        print_verdict;
      end
      `CHK("strobes", run ? exp_cnt(s) : 16'h0000, n)
      `CHK("first", run ? exp_lo(s) : 15'h5555, first)
      `CHK("last", run ? 15'(exp_lo(s) + exp_cnt(s) - 16'h1) : 15'h5555, last)
      `CHK("defaults", s == 8'hff, seen_dflt)
      stat(prog_protected ? `ST_ERR_WRITE : `ST_OK);
    end
    for (int k = 0; k < 2; k++) begin
      host.send(k ? 3'd3 : 3'd5, `ID_ERASE_START, `GRP_START, `START_JUMP, rnd[15:8], rnd[7:0]);
      host.send(3'd0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
      `CHK("jump", 1'b1, jump_ff)
      `CHK("target", k ? 16'h0000 : rnd, jump_addr_ff)
      @(negedge clk);
      `CHK("jump once", 1'b0, jump_ff)
    end
    host.send(3'd3, `ID_ERASE_START, `GRP_START, `START_WDT, rnd[15:8], rnd[7:0]);
    host.send(3'd0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    @(negedge clk);
    `CHK("wdt", 1'b1, wdt_enable_ff)
    host.pulse(0);
    `CHK("silent", 1'b0, status_valid_ff)
    repeat (10) @(negedge clk);
    `CHK("wdt held", 1'b1, wdt_enable_ff)
    print_verdict;
  end
endmodule // dfu_read_erase_start_handler_tb
